// ---- tag_ram_err_pkg.sv ----
// Constants and carrier types for the tag RAM error bank and debug access block
package tag_ram_err_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_LOG_FIRST = 8'h00;
  localparam logic [7:0] OFS_LOG_SECOND = 8'h04;
  localparam logic [7:0] OFS_DEBUG_OP = 8'h08;
  localparam logic [7:0] OFS_DEBUG_DATA = 8'h0C;
  localparam logic [7:0] OFS_DEBUG_CHUNK = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // Error log fields
  localparam int LOG_WAYS_LSB = 16;
  localparam int LOG_INDEX_LSB = 5;
  localparam int LOG_STATUS_LSB = 0;

  // Debug operation fields
  localparam int OP_WAY_LSB = 30;
  localparam int OP_CPU_BIT = 24;
  localparam int OP_INDEX_LSB = 5;
  localparam int OP_DIR_BIT = 0;

  // Debug data fields
  localparam int DATA_VALID_BIT = 22;
  localparam int DATA_TAG_LSB = 17;
  localparam int TAG_MAX_BITS = 5;
  localparam int CHUNK_BITS = 7;

  // Interrupt status bits
  localparam int IRQ_CAPTURE_BIT = 0;
  localparam int IRQ_OVERFLOW_BIT = 1;
  localparam int IRQ_DEBUG_DONE_BIT = 2;
  localparam int IRQ_BITS = 3;

  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [IRQ_BITS-1:0] RESET_IRQ = 3'h0;

  typedef enum logic [1:0] {
    ERR_NONE = 2'b00,
    ERR_SEEN_TAG = 2'b01,
    ERR_SEEN_BOTH = 2'b10,
    ERR_CONFIRMED = 2'b11
  } err_status_t;

  typedef struct packed {
    logic [7:0] ways;
    logic [8:0] index;
    err_status_t status;
  } err_entry_t;

  typedef struct packed {
    logic write;
    logic cpu;
    logic [1:0] way;
    logic [8:0] index;
    logic valid;
    logic [TAG_MAX_BITS-1:0] tag;
    logic [CHUNK_BITS-1:0] chunk;
  } tram_cmd_t;

  typedef struct packed {
    logic valid;
    logic [TAG_MAX_BITS-1:0] tag;
    logic [CHUNK_BITS-1:0] chunk;
  } tram_rsp_t;

endpackage

// ---- tag_ram_error_bank_debug.sv ----
// Tag RAM error bank, debug access path and interrupt logic behind an AHB-Lite slave
`timescale 1ns/1ps

module tag_ram_error_bank_debug #(
  parameter int ECC_EN = 1,
  parameter int TAG_BITS = 5
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic tram_req,
  output tag_ram_err_pkg::tram_cmd_t tram_cmd,
  input wire logic tram_done,
  input wire tag_ram_err_pkg::tram_rsp_t tram_rsp,
  input wire logic ecc_err,
  input wire logic [7:0] ecc_err_ways,
  input wire logic [8:0] ecc_err_index,
  input wire logic cpu_seen,
  input wire logic cpu_seen_entry,
  output logic irq
);

  generate
    if (TAG_BITS < 1 || TAG_BITS > tag_ram_err_pkg::TAG_MAX_BITS || ECC_EN < 0 || ECC_EN > 1)
    begin : g_bad_params
      $error("tag_ram_error_bank_debug: TAG_BITS must be 1..5 and ECC_EN 0 or 1");
    end
  endgenerate

  typedef enum logic [1:0] {
    DBG_IDLE = 2'b00,
    DBG_ISSUE = 2'b01,
    DBG_WAIT = 2'b11
  } dbg_state_t;

  // Tag bits in use sit at the top of the field; lower ones stay reserved
  localparam logic [tag_ram_err_pkg::TAG_MAX_BITS-1:0] TAG_MASK =
    5'h1F << (tag_ram_err_pkg::TAG_MAX_BITS - TAG_BITS);

  function automatic logic [31:0] log_word(input tag_ram_err_pkg::err_entry_t e);
    logic [31:0] w;
    w = tag_ram_err_pkg::RESET_WORD;
    w[tag_ram_err_pkg::LOG_WAYS_LSB +: 8] = e.ways;
    w[tag_ram_err_pkg::LOG_INDEX_LSB +: 9] = e.index;
    w[tag_ram_err_pkg::LOG_STATUS_LSB +: 2] = e.status;
    return w;
  endfunction

  function automatic tag_ram_err_pkg::err_entry_t entry_next(
    input tag_ram_err_pkg::err_entry_t cur,
    input logic capture,
    input logic seen,
    input logic sw_wr,
    input logic [1:0] sw_status,
    input logic [7:0] cap_ways,
    input logic [8:0] cap_index
  );
    tag_ram_err_pkg::err_entry_t n;
    n = cur;
    if (sw_wr && sw_status == tag_ram_err_pkg::ERR_CONFIRMED && cur.status != tag_ram_err_pkg::ERR_NONE)
    begin
      n.status = tag_ram_err_pkg::ERR_CONFIRMED;
    end
    else if (sw_wr && sw_status == tag_ram_err_pkg::ERR_NONE)
    begin
      n.status = tag_ram_err_pkg::ERR_NONE;
    end
    else if (seen && cur.status == tag_ram_err_pkg::ERR_SEEN_TAG)
    begin
      n.status = tag_ram_err_pkg::ERR_SEEN_BOTH;
    end
    if (capture)
    begin
      n.ways = cap_ways;
      n.index = cap_index;
      n.status = tag_ram_err_pkg::ERR_SEEN_TAG;
    end
    return n;
  endfunction

  // Bus data phase state
  logic dphase;
  logic [7:0] dp_addr;
  logic dp_write;

  // Registers
  tag_ram_err_pkg::err_entry_t log_first;
  tag_ram_err_pkg::err_entry_t log_second;
  logic op_dir;
  logic op_cpu;
  logic [1:0] op_way;
  logic [8:0] op_index;
  logic data_valid;
  logic [tag_ram_err_pkg::TAG_MAX_BITS-1:0] data_tag;
  logic [tag_ram_err_pkg::CHUNK_BITS-1:0] chunk;
  logic [tag_ram_err_pkg::IRQ_BITS-1:0] irq_status;
  logic [tag_ram_err_pkg::IRQ_BITS-1:0] irq_mask;
  dbg_state_t dbg_state;

  // Address phase accept
  wire logic addr_take = hsel && hready && htrans[1];

  // The access completes only when the debug engine is idle, so a read of the
  // data or chunk register right after an operation write returns fresh results.
  wire logic dbg_busy = (dbg_state != DBG_IDLE);
  wire logic access_now = dphase && !dbg_busy;
  wire logic wr_now = access_now && dp_write;
  wire logic rd_now = access_now && !dp_write;

  wire logic wr_first = wr_now && dp_addr == tag_ram_err_pkg::OFS_LOG_FIRST;
  wire logic wr_second = wr_now && dp_addr == tag_ram_err_pkg::OFS_LOG_SECOND;
  wire logic wr_op = wr_now && dp_addr == tag_ram_err_pkg::OFS_DEBUG_OP;
  wire logic wr_data = wr_now && dp_addr == tag_ram_err_pkg::OFS_DEBUG_DATA;
  wire logic wr_chunk = wr_now && dp_addr == tag_ram_err_pkg::OFS_DEBUG_CHUNK;
  wire logic wr_mask = wr_now && dp_addr == tag_ram_err_pkg::OFS_IRQ_MASK;
  wire logic rd_irq = rd_now && dp_addr == tag_ram_err_pkg::OFS_IRQ_STATUS;

  wire logic [1:0] sw_status = hwdata[tag_ram_err_pkg::LOG_STATUS_LSB +: 2];

  // Error capture: first free entry takes the error; none free means overflow
  wire logic ecc_on = (ECC_EN != 0);
  wire logic first_free = log_first.status == tag_ram_err_pkg::ERR_NONE;
  wire logic second_free = log_second.status == tag_ram_err_pkg::ERR_NONE;
  wire logic cap_first = ecc_on && ecc_err && first_free;
  wire logic cap_second = ecc_on && ecc_err && !first_free && second_free;
  wire logic overflow = ecc_on && ecc_err && !first_free && !second_free;
  wire logic seen_first = cpu_seen && !cpu_seen_entry;
  wire logic seen_second = cpu_seen && cpu_seen_entry;

  // Capture fields go in as arguments so every change of them reaches the assignment
  wire tag_ram_err_pkg::err_entry_t next_log_first =
    entry_next(log_first, cap_first, seen_first, wr_first, sw_status, ecc_err_ways,
      ecc_err_index);
  wire tag_ram_err_pkg::err_entry_t next_log_second =
    entry_next(log_second, cap_second, seen_second, wr_second, sw_status, ecc_err_ways,
      ecc_err_index);

  wire logic dbg_done = (dbg_state == DBG_WAIT) && tram_done;
  wire logic dbg_rd_done = dbg_done && !op_dir;

  // Events win over the read that clears them
  wire logic [tag_ram_err_pkg::IRQ_BITS-1:0] irq_events =
    {dbg_done, overflow, cap_first || cap_second};
  wire logic [tag_ram_err_pkg::IRQ_BITS-1:0] next_irq_status =
    (rd_irq ? tag_ram_err_pkg::RESET_IRQ : irq_status) | irq_events;

  // Read mux
  wire logic [31:0] op_word =
    {op_way, 5'h00, op_cpu, 10'h000, op_index, 4'h0, op_dir};
  wire logic [31:0] data_word =
    {9'h000, data_valid, data_tag, 17'h00000};
  wire logic [31:0] chunk_word = {25'h0000000, chunk};
  wire logic [31:0] irq_word = {29'h00000000, irq_status};
  wire logic [31:0] mask_word = {29'h00000000, irq_mask};
  wire logic [31:0] rd_word =
    (dp_addr == tag_ram_err_pkg::OFS_LOG_FIRST) ? log_word(log_first) :
    (dp_addr == tag_ram_err_pkg::OFS_LOG_SECOND) ? log_word(log_second) :
    (dp_addr == tag_ram_err_pkg::OFS_DEBUG_OP) ? op_word :
    (dp_addr == tag_ram_err_pkg::OFS_DEBUG_DATA) ? data_word :
    (dp_addr == tag_ram_err_pkg::OFS_DEBUG_CHUNK) ? chunk_word :
    (dp_addr == tag_ram_err_pkg::OFS_IRQ_STATUS) ? irq_word :
    (dp_addr == tag_ram_err_pkg::OFS_IRQ_MASK) ? mask_word :
    tag_ram_err_pkg::RESET_WORD;

  // Debug engine next state
  dbg_state_t next_dbg_state;
  always_comb
  begin
    next_dbg_state = dbg_state;
    unique case (dbg_state)
      DBG_IDLE:
      begin
        if (wr_op)
        begin
          next_dbg_state = DBG_ISSUE;
        end
      end
      DBG_ISSUE:
      begin
        next_dbg_state = DBG_WAIT;
      end
      DBG_WAIT:
      begin
        if (tram_done)
        begin
          next_dbg_state = DBG_IDLE;
        end
      end
      default:
      begin
        next_dbg_state = DBG_IDLE;
      end
    endcase
  end

  // Bus front end: every transfer gets at least one wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dphase <= 1'b0;
      dp_addr <= 8'h00;
      dp_write <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= tag_ram_err_pkg::RESET_WORD;
    end
    else
    begin
      hresp <= 1'b0;
      if (addr_take)
      begin
        dphase <= 1'b1;
        dp_addr <= haddr[7:0];
        dp_write <= hwrite;
        hreadyout <= 1'b0;
      end
      else if (access_now)
      begin
        dphase <= 1'b0;
        hreadyout <= 1'b1;
        hrdata <= dp_write ? tag_ram_err_pkg::RESET_WORD : rd_word;
      end
    end
  end

  // Error bank
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      log_first <= '0;
      log_second <= '0;
    end
    else
    begin
      log_first <= next_log_first;
      log_second <= next_log_second;
    end
  end

  // Debug operation register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      op_way <= 2'h0;
      op_cpu <= 1'b0;
      op_index <= 9'h000;
      op_dir <= 1'b0;
    end
    else if (wr_op)
    begin
      op_way <= hwdata[tag_ram_err_pkg::OP_WAY_LSB +: 2];
      op_cpu <= hwdata[tag_ram_err_pkg::OP_CPU_BIT];
      op_index <= hwdata[tag_ram_err_pkg::OP_INDEX_LSB +: 9];
      op_dir <= hwdata[tag_ram_err_pkg::OP_DIR_BIT];
    end
  end

  // Data and chunk: software loads them, completed reads overwrite them
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      data_valid <= 1'b0;
      data_tag <= 5'h00;
      chunk <= 7'h00;
    end
    else if (dbg_rd_done)
    begin
      data_valid <= tram_rsp.valid;
      data_tag <= tram_rsp.tag & TAG_MASK;
      chunk <= tram_rsp.chunk;
    end
    else
    begin
      if (wr_data)
      begin
        data_valid <= hwdata[tag_ram_err_pkg::DATA_VALID_BIT];
        data_tag <= hwdata[tag_ram_err_pkg::DATA_TAG_LSB +: 5] & TAG_MASK;
      end
      if (wr_chunk)
      begin
        chunk <= hwdata[6:0];
      end
    end
  end

  // Tag RAM access launch; write data goes out unchecked so corrupt
  // tag and check bit pairs can be planted
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dbg_state <= DBG_IDLE;
      tram_req <= 1'b0;
      tram_cmd <= '0;
    end
    else
    begin
      dbg_state <= next_dbg_state;
      tram_req <= (dbg_state == DBG_ISSUE);
      if (dbg_state == DBG_ISSUE)
      begin
        tram_cmd.write <= op_dir;
        tram_cmd.cpu <= op_cpu;
        tram_cmd.way <= op_way;
        tram_cmd.index <= op_index;
        tram_cmd.valid <= data_valid;
        tram_cmd.tag <= data_tag;
        tram_cmd.chunk <= chunk;
      end
    end
  end

  // Interrupts
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_status <= tag_ram_err_pkg::RESET_IRQ;
      irq_mask <= tag_ram_err_pkg::RESET_IRQ;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= next_irq_status;
      if (wr_mask)
      begin
        irq_mask <= hwdata[tag_ram_err_pkg::IRQ_BITS-1:0];
      end
      irq <= |(next_irq_status & irq_mask);
    end
  end

endmodule

// ---- tag_ram_error_bank_debug_assertions.sv ----
// Port checker for the tag RAM error bank and debug access block
`timescale 1ns/1ps
module tag_ram_error_bank_debug_assertions (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic tram_req,
  input wire tag_ram_err_pkg::tram_cmd_t tram_cmd
);
  logic op_ph;
  logic [31:0] op_last;
  wire taken = hsel && hready && htrans[1];
  wire op_end = op_ph && hreadyout;

  // Remember the last completed operation word to compare the launched command
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      op_ph <= 1'b0;
      op_last <= 32'h0000_0000;
    end
    else
    begin
      if (op_end) op_last <= hwdata;
      if (taken) op_ph <= hwrite && haddr[7:0] == tag_ram_err_pkg::OFS_DEBUG_OP;
      else if (hreadyout) op_ph <= 1'b0;
    end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_launch;
    !tram_req ##1 tram_req;
  endsequence

  a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
  a_taken_wait: assert property (taken |=> !hreadyout) else $error("no wait state");
  a_req_pulse: assert property (tram_req |=> !tram_req) else $error("launch not a pulse");
  a_cmd_hold: assert property (tram_cmd != $past(tram_cmd) |-> tram_req)
    else $error("command changed without launch");
  a_op_launch: assert property (op_end |-> ##[0:1] s_launch)
    else $error("operation write did not launch");
  a_cmd_way: assert property (tram_req |-> tram_cmd.way == op_last[31:30])
    else $error("wrong way");
  a_cmd_cpu: assert property (tram_req |-> tram_cmd.cpu == op_last[24])
    else $error("wrong processor");
  a_cmd_index: assert property (tram_req |-> tram_cmd.index == op_last[13:5])
    else $error("wrong index");
  a_cmd_dir: assert property (tram_req |-> tram_cmd.write == op_last[0])
    else $error("wrong direction");
endmodule

bind tag_ram_error_bank_debug tag_ram_error_bank_debug_assertions chk_u (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .tram_req,
  .tram_cmd);

// ---- testbench.sv ----
// Register-level testbench for the tag RAM error bank and debug access block
`timescale 1ns/1ps
module testbench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tram_done = 1'b0;
  logic ecc_err = 1'b0, cpu_seen = 1'b0, cpu_seen_entry = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, op, dv, cv;
  logic [1:0] htrans = 2'h0;
  logic [7:0] ecc_err_ways = 8'h00;
  logic [8:0] ecc_err_index = 9'h000;
  logic hreadyout, hresp, tram_req, irq;
  logic [31:0] hrdata, hrdata_off;
  tag_ram_err_pkg::tram_cmd_t tram_cmd;
  tag_ram_err_pkg::tram_rsp_t tram_rsp = '0;
  logic [12:0] mem [0:4095];
  int dly = 0, checks = 0, n_fail = 0;

  tag_ram_error_bank_debug dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tram_req,
    .tram_cmd, .tram_done, .tram_rsp, .ecc_err, .ecc_err_ways, .ecc_err_index, .cpu_seen,
    .cpu_seen_entry, .irq);

  // Build without ECC protection on the same inputs; its error entries must read zero
  tag_ram_error_bank_debug #(.ECC_EN(0)) dut_noecc_u (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout(), .hresp(),
    .hrdata(hrdata_off), .tram_req(), .tram_cmd(), .tram_done, .tram_rsp, .ecc_err,
    .ecc_err_ways, .ecc_err_index, .cpu_seen, .cpu_seen_entry, .irq());

  initial forever #50 hclk = ~hclk;

  // Tag RAM stand-in; answers after dly extra cycles, then scrambles its data lines
  always @(posedge hclk)
    if (tram_req === 1'b1)
    begin
      if (tram_cmd.write) mem[{tram_cmd.cpu, tram_cmd.way, tram_cmd.index}] = tram_cmd[12:0];
      repeat (dly) @(posedge hclk);
      tram_rsp <= mem[{tram_cmd.cpu, tram_cmd.way, tram_cmd.index}];
      tram_done <= 1'b1;
      @(posedge hclk);
      tram_done <= 1'b0;
      tram_rsp <= ~tram_rsp;
    end

  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    cmp(nm, exp, rd);
  endtask

  task automatic err(input logic [7:0] w, input logic [8:0] ix);
    ecc_err <= 1'b1;
    ecc_err_ways <= w;
    ecc_err_index <= ix;
    @(posedge hclk);
    ecc_err <= 1'b0;
    ecc_err_ways <= ~w;
    @(posedge hclk);
  endtask

  function automatic logic [31:0] ent(logic [7:0] w, logic [8:0] ix, logic [1:0] s);
    return {8'h00, w, 2'h0, ix, 3'h0, s};
  endfunction

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) chk("reset word", 8'(4 * i), 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      dly = 3 * i;
      op = {i[1:0], 5'h00, i[0], 10'h000, 9'h1FF - 9'(9'h025 * i), 4'h0, 1'b1};
      dv = {9'h000, 1'b1, 5'(5'h11 + i), 17'h00000};
      cv = {25'h0, 7'h55 ^ 7'(i)};
      bus(1'b1, tag_ram_err_pkg::OFS_IRQ_MASK, {29'h0, i[0], 2'h0});
      bus(1'b1, tag_ram_err_pkg::OFS_DEBUG_DATA, dv);
      bus(1'b1, tag_ram_err_pkg::OFS_DEBUG_CHUNK, cv);
      bus(1'b1, tag_ram_err_pkg::OFS_DEBUG_OP, op);
      bus(1'b1, tag_ram_err_pkg::OFS_DEBUG_DATA, 32'h0000_0000);
      bus(1'b1, tag_ram_err_pkg::OFS_DEBUG_CHUNK, 32'h0000_0000);
      bus(1'b1, tag_ram_err_pkg::OFS_DEBUG_OP, op & 32'hFFFF_FFFE);
      chk("tag data", tag_ram_err_pkg::OFS_DEBUG_DATA, dv);
      chk("check bits", tag_ram_err_pkg::OFS_DEBUG_CHUNK, cv);
      cmp("irq raised", {31'h0, i[0]}, {31'h0, irq});
      chk("irq status", tag_ram_err_pkg::OFS_IRQ_STATUS, 32'h0000_0004);
      @(posedge hclk);
      cmp("irq cleared", 32'h0, {31'h0, irq});
    end
    $display("test debug access done");
    err(8'hA5, 9'h123);
    err(8'h3C, 9'h0F1);
    err(8'h81, 9'h042);
    chk("first entry", tag_ram_err_pkg::OFS_LOG_FIRST, ent(8'hA5, 9'h123, 2'h1));
    cmp("first without ecc", 32'h0000_0000, hrdata_off);
    chk("second entry", tag_ram_err_pkg::OFS_LOG_SECOND, ent(8'h3C, 9'h0F1, 2'h1));
    chk("capture status", tag_ram_err_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
    cpu_seen <= 1'b1;
    @(posedge hclk);
    cpu_seen <= 1'b0;
    cpu_seen_entry <= 1'b1;
    chk("first seen", tag_ram_err_pkg::OFS_LOG_FIRST, ent(8'hA5, 9'h123, 2'h2));
    chk("second kept", tag_ram_err_pkg::OFS_LOG_SECOND, ent(8'h3C, 9'h0F1, 2'h1));
    bus(1'b1, tag_ram_err_pkg::OFS_LOG_FIRST, 32'h0000_0003);
    chk("first confirmed", tag_ram_err_pkg::OFS_LOG_FIRST, ent(8'hA5, 9'h123, 2'h3));
    bus(1'b1, tag_ram_err_pkg::OFS_LOG_SECOND, 32'h0000_0000);
    bus(1'b0, tag_ram_err_pkg::OFS_LOG_SECOND, 32'h0000_0000);
    cmp("second freed", 32'h0, rd & 32'h0000_0003);
    err(8'h5A, 9'h1C3);
    chk("second reused", tag_ram_err_pkg::OFS_LOG_SECOND, ent(8'h5A, 9'h1C3, 2'h1));
    cmp("second without ecc", 32'h0000_0000, hrdata_off);
    chk("first held", tag_ram_err_pkg::OFS_LOG_FIRST, ent(8'hA5, 9'h123, 2'h3));
    $display("test error bank done");
    test_done;
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge hclk);
    n_fail++;
    $display("watchdog expired");
    test_done;
  end
endmodule
